//--- src/slpc_pkg.sv
// Constants and types for the sleep control and analog status register bank
package slpc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  localparam logic [7:0] ADDR_ANA_CTRL = 8'h01;
  localparam logic [7:0] ADDR_SLP_REQ = 8'h02;
  localparam logic [7:0] ADDR_ANA_STAT = 8'h03;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h05;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h06;

  localparam int PERMIT_BIT = 7;
  localparam int SLP_REQ_BIT = 7;

  localparam int STAT_SLEEP = 7;
  localparam int STAT_REG20 = 6;
  localparam int STAT_CONV2 = 5;
  localparam int STAT_BUS = 4;
  localparam int STAT_FILT = 3;
  localparam int STAT_XTAL = 2;
  localparam int STAT_TW = 1;
  localparam int STAT_TSD = 0;

  localparam logic [7:0] ANA_STAT_RST = 8'h00;
  localparam logic SLP_REQ_RST = 1'b0;
  localparam logic PERMIT_RST = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_TW = 2;
  localparam int IRQ_TSD = 3;
  localparam int IRQ_MON = 4;
  localparam int IRQ_N = 5;
  localparam logic [IRQ_N-1:0] IRQ_RST = 5'h00;

  localparam int MON_N = 7;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } slpc_req_t;

  // Field order matches status bits 6..0
  typedef struct packed {
    logic reg20_ok;
    logic conv2_ok;
    logic bus_ok;
    logic filt_ok;
    logic xtal_ok;
    logic thermal_warn;
    logic thermal_shut;
  } slpc_mon_t;

  typedef enum logic {SLPC_AWAKE, SLPC_ASLEEP} slpc_state_t;

endpackage : slpc_pkg

//--- src/slpc_sync.sv
// Two-flop synchroniser, one per bit
`timescale 1ns/10ps
module slpc_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import slpc_pkg::*;

  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        meta[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        meta[i] <= din[i];
        dout[i] <= meta[i];
      end
    end
  end

endmodule : slpc_sync

//--- src/slpc_irq.sv
// Sticky event status, write-one-to-clear, enable mask and level interrupt
`timescale 1ns/10ps
module slpc_irq #(
  parameter int N = 5
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [N-1:0] event_in,
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  import slpc_pkg::*;

  logic [N-1:0] next_status;
  logic [N-1:0] next_enable;
  logic next_irq;

  always_comb begin
    next_status = status;
    next_enable = enable;
    if (clr_wr) begin
      next_status = status & ~wdata;
    end
    // New events win over a clear in the same cycle
    next_status = next_status | event_in;
    if (en_wr) begin
      next_enable = wdata;
    end
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
      enable <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      irq <= next_irq;
    end
  end

endmodule : slpc_irq

//--- src/slpc_top.sv
// Sleep control, analog status byte and register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module slpc_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire slpc_pkg::slpc_req_t bus_req,
  input wire slpc_pkg::slpc_mon_t mon_in,
  input wire logic wake_input_pin,
  output logic [slpc_pkg::DATA_W-1:0] rd_data,
  output logic sleep_active,
  output logic irq
);
  import slpc_pkg::*;

  slpc_state_t state;
  slpc_state_t next_state;
  logic sleep_request;
  logic next_sleep_request;
  logic sleep_permit;
  logic next_sleep_permit;
  logic sleep_state_flag;
  logic next_sleep_state_flag;
  logic next_sleep_active;
  logic [DATA_W-1:0] next_rd_data;

  slpc_mon_t mon_s;
  slpc_mon_t mon_d;
  slpc_mon_t next_mon_d;
  logic wake_s;
  logic wake_d;
  logic next_wake_d;

  logic wr_ctrl;
  logic wr_slp;
  logic rd_stat;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic sleep_go;
  logic wake_evt;
  logic mon_drop;
  logic [DATA_W-1:0] status_byte;
  logic [IRQ_N-1:0] events;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_enable;

  // Monitor and wake inputs are brought onto mclk
  slpc_sync #(
    .W(MON_N + 1)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .din({mon_in, wake_input_pin}),
    .dout({mon_s, wake_s})
  );

  assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_ANA_CTRL);
  assign wr_slp = bus_req.wr && (bus_req.addr == ADDR_SLP_REQ);
  assign rd_stat = bus_req.rd && (bus_req.addr == ADDR_ANA_STAT);
  assign wr_irq_clr = bus_req.wr && (bus_req.addr == ADDR_IRQ_CLR);
  assign wr_irq_en = bus_req.wr && (bus_req.addr == ADDR_IRQ_EN);

  assign sleep_go = (state == SLPC_AWAKE) && sleep_request && sleep_permit;
  assign wake_evt = (state == SLPC_ASLEEP) && wake_s && !wake_d;

  // Status byte built live from the synchronised monitors
  assign status_byte = {sleep_state_flag, mon_s};

  assign mon_drop = |((~{mon_s.reg20_ok, mon_s.conv2_ok, mon_s.bus_ok,
                         mon_s.filt_ok, mon_s.xtal_ok}) &
                      {mon_d.reg20_ok, mon_d.conv2_ok, mon_d.bus_ok,
                       mon_d.filt_ok, mon_d.xtal_ok});

  always_comb begin
    events = '0;
    events[IRQ_SLEEP] = sleep_go;
    events[IRQ_WAKE] = wake_evt;
    events[IRQ_TW] = mon_s.thermal_warn && !mon_d.thermal_warn;
    events[IRQ_TSD] = mon_s.thermal_shut && !mon_d.thermal_shut;
    events[IRQ_MON] = mon_drop;
  end

  slpc_irq #(
    .N(IRQ_N)
  ) u_irq (
    .mclk(mclk),
    .rst_b(rst_b),
    .event_in(events),
    .clr_wr(wr_irq_clr),
    .en_wr(wr_irq_en),
    .wdata(bus_req.wdata[IRQ_N-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // Sleep state machine and control bits
  always_comb begin
    next_state = state;
    next_sleep_request = sleep_request;
    next_sleep_permit = sleep_permit;
    next_sleep_state_flag = sleep_state_flag;
    if (wr_ctrl) begin
      next_sleep_permit = bus_req.wdata[PERMIT_BIT];
    end
    if (wr_slp) begin
      // Reserved bits are not stored
      next_sleep_request = bus_req.wdata[SLP_REQ_BIT];
    end
    unique case (state)
      SLPC_AWAKE: begin
        if (sleep_go) begin
          next_state = SLPC_ASLEEP;
        end
      end
      SLPC_ASLEEP: begin
        // Register writes cannot end sleep; only the wake edge does
        if (wake_evt) begin
          next_state = SLPC_AWAKE;
          next_sleep_request = 1'b0;
        end
      end
    endcase
    // Flag is cleared by a status read while awake, entry into sleep wins
    if (rd_stat && (state == SLPC_AWAKE)) begin
      next_sleep_state_flag = 1'b0;
    end
    if (sleep_go) begin
      next_sleep_state_flag = 1'b1;
    end
    next_sleep_active = (next_state == SLPC_ASLEEP);
    next_mon_d = mon_s;
    next_wake_d = wake_s;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SLPC_AWAKE;
      sleep_request <= SLP_REQ_RST;
      sleep_permit <= PERMIT_RST;
      sleep_state_flag <= ANA_STAT_RST[STAT_SLEEP];
      sleep_active <= 1'b0;
      mon_d <= '0;
      wake_d <= 1'b0;
    end else begin
      state <= next_state;
      sleep_request <= next_sleep_request;
      sleep_permit <= next_sleep_permit;
      sleep_state_flag <= next_sleep_state_flag;
      sleep_active <= next_sleep_active;
      mon_d <= next_mon_d;
      wake_d <= next_wake_d;
    end
  end

  // Read mux; data stand in the cycle after the strobe only
  always_comb begin
    next_rd_data = READ_ZERO;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_ANA_CTRL: begin
          next_rd_data[PERMIT_BIT] = sleep_permit;
        end
        ADDR_SLP_REQ: begin
          next_rd_data[SLP_REQ_BIT] = sleep_request;
        end
        ADDR_ANA_STAT: begin
          next_rd_data = status_byte;
        end
        ADDR_IRQ_STAT: begin
          next_rd_data[IRQ_N-1:0] = irq_status;
        end
        ADDR_IRQ_EN: begin
          next_rd_data[IRQ_N-1:0] = irq_enable;
        end
        default: begin
          next_rd_data = READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= READ_ZERO;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_enter;
    !sleep_active ##1 sleep_active;
  endsequence

  sequence s_stat_rd;
    bus_req.rd && (bus_req.addr == ADDR_ANA_STAT);
  endsequence

  sequence s_wake_rise;
    $rose(wake_s);
  endsequence

  chk_sleep_entry: assert property (
    sleep_go |=> sleep_active ##0 sleep_state_flag)
    else $error("sleep not entered on permitted request");

  chk_permit_gate: assert property (
    (!sleep_active && !sleep_permit) |=> !sleep_active)
    else $error("sleep entered without permit");

  chk_sleep_hold: assert property (
    (sleep_active && !(wake_s && !wake_d)) |=> sleep_active)
    else $error("sleep left without wake edge");

  chk_wake_exit: assert property (
    wake_evt |=> !sleep_active && !sleep_request)
    else $error("wake edge did not end sleep");

  chk_reserved_zero: assert property (
    (bus_req.rd && (bus_req.addr == ADDR_SLP_REQ)) |=> (rd_data[6:0] == 7'h00))
    else $error("reserved request bits read nonzero");

  chk_status_read: assert property (
    s_stat_rd |=> (rd_data == $past(status_byte)))
    else $error("status read data wrong");

  chk_reg20_bit: assert property (
    s_stat_rd |=> (rd_data[STAT_REG20] == $past(mon_s.reg20_ok)))
    else $error("regulator bit wrong");

  chk_flag_set: assert property (
    s_enter |-> sleep_state_flag ##1 sleep_state_flag)
    else $error("sleep state flag not set");

  chk_stat_write: assert property (
    (bus_req.wr && (bus_req.addr == ADDR_ANA_STAT) && !sleep_go && !wake_evt)
      |=> $stable(sleep_state_flag) && $stable(state))
    else $error("status write had an effect");

  chk_irq_level: assert property (
    irq == |(irq_status & irq_enable))
    else $error("interrupt level mismatch");

  chk_permit_write: assert property (
    wr_ctrl |=> (sleep_permit == $past(bus_req.wdata[PERMIT_BIT])))
    else $error("sleep permit not stored");

  chk_ctrl_read: assert property (
    (bus_req.rd && (bus_req.addr == ADDR_ANA_CTRL)) |=> (rd_data == {$past(sleep_permit), 7'h00}))
    else $error("control read data wrong");

  chk_req_write: assert property (
    (wr_slp && !wake_evt) |=> (sleep_request == $past(bus_req.wdata[SLP_REQ_BIT])))
    else $error("sleep request not stored");

  chk_idle_read: assert property (
    !bus_req.rd |=> (rd_data == READ_ZERO))
    else $error("read data held past its cycle");

  chk_unmapped_read: assert property (
    (bus_req.rd && (bus_req.addr > ADDR_IRQ_EN)) |=> (rd_data == READ_ZERO))
    else $error("unmapped read nonzero");

  chk_flag_clear: assert property (
    (rd_stat && !sleep_active && !sleep_go) |=> !sleep_state_flag)
    else $error("sleep state flag not cleared by read");

  chk_flag_sticky: assert property (
    (sleep_state_flag && !rd_stat) |=> sleep_state_flag)
    else $error("sleep state flag lost");

  chk_sleep_bit: assert property (
    s_stat_rd |=> (rd_data[STAT_SLEEP] == $past(sleep_state_flag)))
    else $error("sleep state bit wrong");

  chk_thermal_bits: assert property (
    s_stat_rd |=> (rd_data[STAT_TW] == $past(mon_s.thermal_warn)) &&
      (rd_data[STAT_TSD] == $past(mon_s.thermal_shut)))
    else $error("thermal bits wrong");

  chk_supply_bits: assert property (
    s_stat_rd |=> (rd_data[STAT_CONV2] == $past(mon_s.conv2_ok)) &&
      (rd_data[STAT_BUS] == $past(mon_s.bus_ok)))
    else $error("supply monitor bits wrong");

  chk_sleep_irq: assert property (
    sleep_go |=> irq_status[IRQ_SLEEP])
    else $error("sleep entry event not recorded");

  chk_wake_irq: assert property (
    wake_evt |=> irq_status[IRQ_WAKE])
    else $error("wake event not recorded");

  chk_irq_clear: assert property (
    (wr_irq_clr && (events == '0)) |=> ((irq_status & $past(bus_req.wdata[IRQ_N-1:0])) == '0))
    else $error("interrupt status not cleared");

  chk_wake_edge: assert property (
    (sleep_active ##0 s_wake_rise) |=> !sleep_active)
    else $error("wake pin edge did not end sleep");

  chk_awake_hold: assert property (
    (!sleep_active && !sleep_go) |=> !sleep_active)
    else $error("sleep entered without request");

endmodule : slpc_top

//--- verification/slpc_host_model.sv
// Host model that issues register cycles on the plain register port
`timescale 1ns/10ps
module slpc_host_model (
  input wire logic mclk,
  input wire logic [slpc_pkg::DATA_W-1:0] rd_data,
  output slpc_pkg::slpc_req_t bus_req
);
  import slpc_pkg::*;

  initial begin
    bus_req = '0;
  end

  // One-cycle write strobe; data lines are scrambled once the cycle is over
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    bus_req.wdata <= ~d;
  endtask : wr

  // Read data is taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    bus_req.addr <= ~a;
    @(negedge mclk);
    d = rd_data;
  endtask : rd
endmodule : slpc_host_model

//--- verification/tb.sv
// Self-checking testbench for the sleep control and analog status bank
`timescale 1ns/10ps
module tb;
  import slpc_pkg::*;
  logic mclk;
  logic rst_b;
  logic wake_input_pin;
  logic sleep_active;
  logic irq;
  slpc_req_t bus_req;
  slpc_mon_t mon_in;
  logic [7:0] rd_data;
  logic [7:0] d;
  int err_total;
  int total_checks;

  slpc_top dut_u (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .mon_in(mon_in),
    .wake_input_pin(wake_input_pin), .rd_data(rd_data), .sleep_active(sleep_active),
    .irq(irq));
  slpc_host_model host_u (.mclk(mclk), .rd_data(rd_data), .bus_req(bus_req));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic wait_sleep(input logic lvl);
    for (int k = 0; k < 20 && sleep_active !== lvl; k++) @(negedge mclk);
    chk({7'h00, sleep_active}, {7'h00, lvl});
    if (sleep_active !== lvl) print_verdict();
  endtask : wait_sleep

  task automatic t_reset;
    host_u.rd(ADDR_ANA_STAT, d);
    chk(d, ANA_STAT_RST);
    host_u.rd(ADDR_ANA_CTRL, d);
    chk(d, 8'h00);
    host_u.rd(ADDR_SLP_REQ, d);
    chk(d, 8'h00);
    host_u.rd(8'h10, d);
    chk(d, READ_ZERO);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_monitors;
    for (int i = 0; i < MON_N; i++) begin
      @(posedge mclk);
      mon_in <= slpc_mon_t'(7'(1 << i));
      repeat (3) @(posedge mclk);
      host_u.rd(ADDR_ANA_STAT, d);
      chk(d, 8'(1 << i));
    end
    host_u.wr(ADDR_ANA_STAT, 8'hFF);
    host_u.rd(ADDR_ANA_STAT, d);
    chk(d, 8'h40);
    @(posedge mclk);
    mon_in <= '0;
    repeat (4) @(posedge mclk);
    // Thermal rises and monitor drops from the walk above
    host_u.rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h1C);
    host_u.wr(ADDR_IRQ_CLR, 8'h1F);
    host_u.rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h00);
    $display("test monitor order done");
  endtask : t_monitors

  task automatic t_sleep;
    host_u.wr(ADDR_IRQ_EN, 8'h01);
    host_u.rd(ADDR_IRQ_EN, d);
    chk(d, 8'h01);
    // Reserved bits written on purpose to show they are not stored
    host_u.wr(ADDR_SLP_REQ, 8'hFF);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, sleep_active}, 8'h00);
    host_u.rd(ADDR_SLP_REQ, d);
    chk(d, 8'h80);
    host_u.wr(ADDR_ANA_CTRL, 8'h80);
    wait_sleep(1'b1);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, irq}, 8'h01);
    // Request left set while asleep; the wake edge clears it, as would a request write of 0
    host_u.wr(ADDR_SLP_REQ, 8'h80);
    host_u.wr(ADDR_ANA_CTRL, 8'h00);
    host_u.rd(ADDR_ANA_STAT, d);
    chk(d, 8'h80);
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, sleep_active}, 8'h01);
    @(posedge mclk);
    wake_input_pin <= 1'b1;
    wait_sleep(1'b0);
    host_u.rd(ADDR_SLP_REQ, d);
    chk(d, 8'h00);
    host_u.rd(ADDR_ANA_STAT, d);
    chk(d, 8'h80);
    host_u.rd(ADDR_ANA_STAT, d);
    chk(d, 8'h00);
    host_u.rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h03);
    host_u.wr(ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, irq}, 8'h00);
    host_u.wr(ADDR_IRQ_CLR, 8'h03);
    host_u.rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h00);
    @(posedge mclk);
    wake_input_pin <= 1'b0;
    $display("test sleep and wake done");
  endtask : t_sleep

  initial begin
    rst_b = 1'b0;
    mon_in = '0;
    wake_input_pin = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_monitors();
    t_sleep();
    print_verdict();
  end

  // Hang guard
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule : tb
